/* File: logic/detu_top.sv */
`timescale 1ns/100ps
// Behaviour
// [R1] basic timer counts up, rolls FF to 00, keeps counting, raises a time-out.
// [R2] real-time mode gives a time-out every half second, ignoring count and rate.
// [R3] source bit 0 picks cpu prescaler or 32768 Hz low clock real-time source.
// [R4] an enabled basic timer time-out wakes the system from green mode.
// [R5] basic rate bits 6..4: code 000 divides by 256, 111 by 2.
// [R6] basic enable bit 7 stops or runs the basic timer.
// [R7] basic count is read/write; a write sets where counting resumes.
// [R8] software disables, clears, configures, loads, enables irq, then enables timer.
// [R9] general timer counts up, overflows FF to 00, raises a request each overflow.
// [R10] fast select bit 2 feeds the general prescaler from cpu or osc clock.
// [R11] general rate: cpu divided 256..2, or osc divided 128..1.
// [R12] pwm bit 0 enables pwm; reload and toggle bits set its boundary.
// [R13] toggle bit 1, outside pwm, hands the shared pin to the toggle signal.
// [R14] reload bit 2, outside pwm, enables reload at overflow.
// [R15] general enable bit 7 halts counter, toggle and pwm when clear.
// [R16] general wake bit 1 lets a general time-out wake from green mode.
// [R17] second timer fast bit 3 picks cpu or osc prescaler source.
// [R18] overflow with reload copies reload value into count; pwm forces reload.
// [R19] toggle output inverts at each general overflow, half the overflow rate.
// [R20] a disabled timer holds its count and produces no events.
// [R21] prescalers run freely; counters step once per prescaler pulse.
module detu_top #(
  parameter int RTC_COUNT = detu_pkg::RTC_TICKS,
  parameter int RTC_W = 14
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register bus
  input wire detu_pkg::detu_apb_req_t apb_req,
  output detu_pkg::detu_apb_rsp_t apb_rsp,
  // rate enables, one-cycle pulses
  input wire logic cpu_tick,
  input wire logic osc_tick,
  input wire logic lowclk_tick,
  // power state
  input wire logic green_mode,
  // requests and wake-up
  output logic btimer_irq,
  output logic gtimer_irq,
  output logic btimer_wake,
  output logic gtimer_wake,
  // shared output pin
  output logic shared_pin_out,
  output logic shared_pin_oe_n,
  // second general timer source
  output logic second_timer_fast_sel
);
  import detu_pkg::*;

  typedef struct packed {
    logic [7:0] bmode;
    logic [7:0] gmode;
    logic [7:0] greload;
    logic bflag;
    logic bien;
    logic gflag;
    logic gien;
    logic [RTC_W-1:0] rtc_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic birq;
    logic girq;
    logic bwake;
    logic gwake;
    logic pin_out;
    logic pin_oe_n;
    logic t1fast;
  } detu_top_state_t;

  detu_top_state_t s_q, s_d;

  logic acc_start;
  logic commit;
  logic wr_en;
  logic wr_bmode;
  logic wr_bcount;
  logic wr_gmode;
  logic wr_gcount;
  logic wr_greload;
  logic wr_irq;
  logic [31:0] rd_data;
  logic rd_ok;
  logic b_en;
  logic b_rtc;
  logic g_en;
  logic g_pwm;
  logic g_fast;
  logic [3:0] b_shift;
  logic [3:0] g_shift;
  logic b_psc_tick;
  logic g_psc_tick;
  logic [7:0] bcount;
  logic [7:0] gcount;
  logic b_ovf;
  logic g_ovf;
  logic [7:0] g_top;
  logic rtc_done;
  logic b_timeout;
  logic pwm_level;
  logic [7:0] pwm_msb;

  // bus phases: one wait state, so pready and prdata both come from flops
  assign acc_start = apb_req.psel & apb_req.penable & ~s_q.pready;
  assign commit = apb_req.psel & apb_req.penable & s_q.pready;
  assign wr_en = commit & apb_req.pwrite;
  assign wr_bmode = wr_en & detu_hit(apb_req.paddr, IDX_BTIMER_MODE);
  assign wr_bcount = wr_en & detu_hit(apb_req.paddr, IDX_BTIMER_COUNT);
  assign wr_gmode = wr_en & detu_hit(apb_req.paddr, IDX_GTIMER_MODE);
  assign wr_gcount = wr_en & detu_hit(apb_req.paddr, IDX_GTIMER_COUNT);
  assign wr_greload = wr_en & detu_hit(apb_req.paddr, IDX_GTIMER_RELOAD);
  assign wr_irq = wr_en & detu_hit(apb_req.paddr, IDX_IRQ_CTRL);

  // mode decode
  assign b_en = s_q.bmode[BM_ENABLE]; // [R6]
  assign b_rtc = s_q.bmode[BM_RTC]; // [R3]
  assign g_en = s_q.gmode[GM_ENABLE]; // [R15]
  assign g_pwm = s_q.gmode[GM_PWM]; // [R12]
  assign g_fast = s_q.bmode[BM_G_FAST]; // [R10]
  assign b_shift = detu_shift(s_q.bmode[BM_RATE_LSB +: 3], 1'h0); // [R5]
  assign g_shift = detu_shift(s_q.gmode[GM_RATE_LSB +: 3], g_fast); // [R11]

  detu_prescaler u_bpsc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .src_tick(cpu_tick),
    .shift(b_shift),
    .tick_out(b_psc_tick)
  );

  // general prescaler source follows the fast select
  detu_prescaler u_gpsc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .src_tick(g_fast ? osc_tick : cpu_tick), // [R10]
    .shift(g_shift),
    .tick_out(g_psc_tick)
  );

  // basic counter is frozen in real-time mode, its load value is ignored
  detu_counter #(.W(8)) u_bcnt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(b_en & ~b_rtc), // [R2]
    .tick(b_psc_tick),
    .top(8'hFF), // [R1]
    .reload_en(1'h0),
    .reload_val(RST_COUNT),
    .wr(wr_bcount),
    .wdata(apb_req.pwdata[7:0]),
    .count(bcount),
    .ovf(b_ovf)
  );

  // pwm forces reload and moves the boundary
  assign g_top = g_pwm ? detu_pwm_top(s_q.gmode[GM_ALOAD], s_q.gmode[GM_TOUT]) : 8'hFF;

  detu_counter #(.W(8)) u_gcnt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(g_en), // [R15]
    .tick(g_psc_tick),
    .top(g_top), // [R9] [R12]
    .reload_en(g_pwm | s_q.gmode[GM_ALOAD]), // [R14] [R18]
    .reload_val(s_q.greload),
    .wr(wr_gcount),
    .wdata(apb_req.pwdata[7:0]),
    .count(gcount),
    .ovf(g_ovf)
  );

  // real-time interval counted in low clock ticks
  assign rtc_done = b_en & b_rtc & lowclk_tick &
                    (s_q.rtc_cnt == RTC_W'(RTC_COUNT - 1)); // [R2]
  assign b_timeout = b_rtc ? rtc_done : b_ovf; // [R1] [R2]

  // pwm is high in the lower half of the counting window
  assign pwm_msb = g_top ^ (g_top >> 1);
  assign pwm_level = ~|(gcount & pwm_msb);

  // read mux; the reload value is write-only and reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'h1;
    if (detu_hit(apb_req.paddr, IDX_BTIMER_MODE)) begin
      rd_data[7:0] = s_q.bmode;
    end else if (detu_hit(apb_req.paddr, IDX_BTIMER_COUNT)) begin
      rd_data[7:0] = bcount; // [R7]
    end else if (detu_hit(apb_req.paddr, IDX_GTIMER_MODE)) begin
      rd_data[7:0] = s_q.gmode;
    end else if (detu_hit(apb_req.paddr, IDX_GTIMER_COUNT)) begin
      rd_data[7:0] = gcount;
    end else if (detu_hit(apb_req.paddr, IDX_GTIMER_RELOAD)) begin
      rd_data[7:0] = 8'h00;
    end else if (detu_hit(apb_req.paddr, IDX_IRQ_CTRL)) begin
      rd_data[IC_BFLAG] = s_q.bflag;
      rd_data[IC_BIEN] = s_q.bien;
      rd_data[IC_GFLAG] = s_q.gflag;
      rd_data[IC_GIEN] = s_q.gien;
    end else begin
      rd_ok = 1'h0;
    end
  end

  // next state
  always_comb begin
    s_d = s_q;
    // bus answer
    s_d.pready = acc_start;
    if (acc_start) begin
      s_d.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_data;
      s_d.pslverr = ~rd_ok;
    end else begin
      s_d.pslverr = 1'h0;
    end
    // register writes
    if (wr_bmode) begin
      s_d.bmode = apb_req.pwdata[7:0];
    end
    if (wr_gmode) begin
      s_d.gmode = apb_req.pwdata[7:0] & GM_WMASK;
    end
    if (wr_greload) begin
      s_d.greload = apb_req.pwdata[7:0];
    end
    if (wr_irq) begin
      s_d.bflag = apb_req.pwdata[IC_BFLAG];
      s_d.bien = apb_req.pwdata[IC_BIEN];
      s_d.gflag = apb_req.pwdata[IC_GFLAG];
      s_d.gien = apb_req.pwdata[IC_GIEN];
    end
    // a time-out in the clearing cycle still sets the flag
    if (b_timeout) begin
      s_d.bflag = 1'h1; // [R1]
    end
    if (g_ovf) begin
      s_d.gflag = 1'h1; // [R9]
    end
    // real-time counter holds while disabled or in prescaler mode
    if (b_en & b_rtc & lowclk_tick) begin
      s_d.rtc_cnt = rtc_done ? '0 : s_q.rtc_cnt + RTC_W'(1); // [R2] [R20]
    end
    s_d.birq = s_d.bflag & s_d.bien;
    s_d.girq = s_d.gflag & s_d.gien;
    // wake only while asleep; disabled timers make no time-out
    s_d.bwake = green_mode & b_timeout; // [R4] [R20]
    s_d.gwake = green_mode & g_ovf & s_q.bmode[BM_G_WAKE]; // [R16]
    // shared pin: pwm wins over the toggle output
    s_d.pin_oe_n = ~(g_pwm | s_q.gmode[GM_TOUT]); // [R13]
    if (g_en) begin
      if (g_pwm) begin
        s_d.pin_out = pwm_level; // [R12]
      end else if (g_ovf) begin
        s_d.pin_out = ~s_q.pin_out; // [R19]
      end
    end
    s_d.t1fast = s_q.bmode[BM_T1_FAST]; // [R17]
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.pin_oe_n <= 1'h1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign apb_rsp.prdata = s_q.prdata;
  assign apb_rsp.pready = s_q.pready;
  assign apb_rsp.pslverr = s_q.pslverr;
  assign btimer_irq = s_q.birq;
  assign gtimer_irq = s_q.girq;
  assign btimer_wake = s_q.bwake;
  assign gtimer_wake = s_q.gwake;
  assign shared_pin_out = s_q.pin_out;
  assign shared_pin_oe_n = s_q.pin_oe_n;
  assign second_timer_fast_sel = s_q.t1fast;

  sequence s_acc_wait;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence

  sequence s_bcount_write;
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
      detu_hit(apb_req.paddr, IDX_BTIMER_COUNT);
  endsequence

  a_apb_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_acc_wait |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("bus answer not one cycle after access");
  a_bcount_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_bcount_write |=> bcount == $past(apb_req.pwdata[7:0])) // [R7]
    else $error("basic count write lost");
  a_bflag_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    b_timeout |=> s_q.bflag) // [R1]
    else $error("basic time-out did not set its flag");
  a_rtc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    b_rtc && !wr_bcount |=> $stable(bcount)) // [R2]
    else $error("basic count moved in real-time mode");
  a_bwake_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    b_timeout && green_mode |=> btimer_wake ##1 !btimer_wake || $past(b_timeout)) // [R4]
    else $error("basic wake pulse wrong");
  a_gwake_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    gtimer_wake |-> $past(s_q.bmode[BM_G_WAKE]) && $past(g_ovf) && $past(green_mode)) // [R16]
    else $error("general wake without enable");
  a_toggle_flip: assert property (@(posedge clk_sys) disable iff (sys_rst)
    g_en && !g_pwm && g_ovf |=> shared_pin_out != $past(shared_pin_out)) // [R19]
    else $error("toggle output missed an overflow");
  a_pin_release: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !g_pwm && !s_q.gmode[GM_TOUT] |=> shared_pin_oe_n) // [R13]
    else $error("pin taken while toggle output is off");
  a_halt_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !g_en |=> $stable(shared_pin_out) && !gtimer_wake) // [R15]
    else $error("halted general timer changed its outputs");

  // wake, divider, reload, pin and source select checks; a stray wake would pull the system out of sleep
  a_bwake_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    btimer_wake |-> $past(green_mode) && $past(b_timeout)) // [R4]
    else $error("basic wake without a time-out in green mode");
  a_bwake_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !b_en |=> !btimer_wake) // [R20]
    else $error("disabled basic timer woke the system");
  a_rtc_div_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(b_en && b_rtc) |=> $stable(s_q.rtc_cnt)) // [R20]
    else $error("real-time divider moved while idle");
  a_rtc_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rtc_done |=> s_q.rtc_cnt == '0) // [R2]
    else $error("real-time divider did not restart");
  a_pwm_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    g_pwm && g_ovf && !wr_gcount |=> gcount == $past(s_q.greload)) // [R18]
    else $error("pwm overflow did not reload");
  a_pin_owner: assert property (@(posedge clk_sys) disable iff (sys_rst)
    g_pwm || s_q.gmode[GM_TOUT] |=> !shared_pin_oe_n) // [R13]
    else $error("timer output not driving the shared pin");
  a_second_fast: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> second_timer_fast_sel == $past(s_q.bmode[BM_T1_FAST])) // [R17]
    else $error("second timer source select not exported");

endmodule

/* File: logic/detu_pkg.sv */
package detu_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_BTIMER_MODE = 8'hD8;
  localparam logic [7:0] IDX_BTIMER_COUNT = 8'hD9;
  localparam logic [7:0] IDX_GTIMER_MODE = 8'hDA;
  localparam logic [7:0] IDX_GTIMER_COUNT = 8'hDB;
  localparam logic [7:0] IDX_GTIMER_RELOAD = 8'hCD;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'hF0;

  // basic_timer_mode fields
  localparam int BM_ENABLE = 7;
  localparam int BM_RATE_LSB = 4;
  localparam int BM_T1_FAST = 3;
  localparam int BM_G_FAST = 2;
  localparam int BM_G_WAKE = 1;
  localparam int BM_RTC = 0;

  // general_timer_mode fields; bit 3 is reserved and reads zero
  localparam int GM_ENABLE = 7;
  localparam int GM_RATE_LSB = 4;
  localparam int GM_ALOAD = 2;
  localparam int GM_TOUT = 1;
  localparam int GM_PWM = 0;
  localparam logic [7:0] GM_WMASK = 8'hF7;

  // irq control fields
  localparam int IC_BFLAG = 0;
  localparam int IC_BIEN = 1;
  localparam int IC_GFLAG = 2;
  localparam int IC_GIEN = 3;

  // reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // real-time tick from the low clock
  localparam int LOWCLK_HZ = 32768;
  localparam int RTC_PERIOD_MS = 500;
  localparam int RTC_TICKS = LOWCLK_HZ * RTC_PERIOD_MS / 1000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } detu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } detu_apb_rsp_t;

  // divider exponent: cpu source 256..2, osc source 128..1
  function automatic logic [3:0] detu_shift(input logic [2:0] code, input logic fast);
    detu_shift = fast ? (4'h7 - {1'h0, code}) : (4'h8 - {1'h0, code});
  endfunction

  // aligned word hit on one register index
  function automatic logic detu_hit(input logic [11:0] addr, input logic [7:0] idx);
    detu_hit = (addr == {2'h0, idx, 2'h0});
  endfunction

  // pwm overflow boundary chosen by the reload and toggle bits
  function automatic logic [7:0] detu_pwm_top(input logic aload, input logic tout);
    case ({aload, tout})
      2'h0: detu_pwm_top = 8'hFF;
      2'h1: detu_pwm_top = 8'h3F;
      2'h2: detu_pwm_top = 8'h7F;
      default: detu_pwm_top = 8'h1F;
    endcase
  endfunction

endpackage

/* File: logic/detu_prescaler.sv */
`timescale 1ns/100ps
module detu_prescaler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // source and selection
  input wire logic src_tick,
  input wire logic [3:0] shift,
  // divided pulse
  output logic tick_out
);
  import detu_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } detu_psc_state_t;

  detu_psc_state_t s_q, s_d;
  logic [7:0] mask;

  // free-running, so a rate change never restarts the phase
  assign mask = 8'((9'h001 << shift) - 9'h001);

  always_comb begin
    s_d = s_q;
    s_d.tick = src_tick & ((s_q.cnt & mask) == mask); // [R21]
    if (src_tick) begin
      s_d.cnt = s_q.cnt + 8'h01; // [R21]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

  a_tick_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick_out |-> $past(src_tick)) // [R21]
    else $error("prescaler pulse without a source tick");

endmodule

/* File: logic/detu_counter.sv */
`timescale 1ns/100ps
module detu_counter #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire logic tick,
  input wire logic [W-1:0] top,
  input wire logic reload_en,
  input wire logic [W-1:0] reload_val,
  // software load
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] count,
  output logic ovf
);
  import detu_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } detu_cnt_state_t;

  detu_cnt_state_t s_q, s_d;

  // overflow at the boundary, only while enabled
  assign ovf = enable & tick & (s_q.cnt == top); // [R1] [R9] [R20]

  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.cnt = wdata; // [R7]
    end else if (ovf) begin
      s_d.cnt = reload_en ? reload_val : '0; // [R18]
    end else if (enable & tick) begin
      s_d.cnt = s_q.cnt + W'(1); // [R21]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;

  sequence s_step;
    enable && tick && !wr;
  endsequence

  a_count_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !enable && !wr |=> $stable(count)) // [R20]
    else $error("disabled counter moved");
  a_count_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_step ##0 (count != top) |=> count == $past(count) + W'(1)) // [R21]
    else $error("counter did not advance by one");
  a_ovf_reload: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_step ##0 (count == top) && reload_en |=> count == $past(reload_val)) // [R18]
    else $error("reload value not copied at overflow");
  a_ovf_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_step ##0 (count == top) && !reload_en |=> count == '0) // [R1]
    else $error("counter did not roll to zero");

endmodule

/* File: testbench/detu_top_test.sv */
`timescale 1ns/100ps
// one comparison, counted; a mismatch is reported at once
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module detu_top_test;
  import detu_pkg::*;
  localparam int RTC_SIM = 8;
  localparam logic [11:0] A_BM = {2'h0, IDX_BTIMER_MODE, 2'h0};
  localparam logic [11:0] A_BC = {2'h0, IDX_BTIMER_COUNT, 2'h0};
  localparam logic [11:0] A_GM = {2'h0, IDX_GTIMER_MODE, 2'h0};
  localparam logic [11:0] A_GC = {2'h0, IDX_GTIMER_COUNT, 2'h0};
  localparam logic [11:0] A_GR = {2'h0, IDX_GTIMER_RELOAD, 2'h0};
  localparam logic [11:0] A_IC = {2'h0, IDX_IRQ_CTRL, 2'h0};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  detu_apb_req_t req = '0;
  detu_apb_rsp_t rsp;
  logic cpu_tick = 1'b1;
  logic osc_tick = 1'b0;
  logic lowclk_tick = 1'b0;
  logic green_mode = 1'b1;
  logic [1:0] lc = 2'h0;
  logic btimer_irq, gtimer_irq, btimer_wake, gtimer_wake;
  logic shared_pin_out, shared_pin_oe_n, second_timer_fast_sel;
  int err_total = 0;
  int n_compared = 0;
  int seed = 91549;
  int cyc, e, k, f;
  logic [31:0] rd;
  logic err, p;
  logic [7:0] r;
  logic [11:0] al [6] = '{A_BM, A_BC, A_GM, A_GC, A_GR, A_IC};

  detu_top #(.RTC_COUNT(RTC_SIM), .RTC_W(14)) detu_top_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .cpu_tick(cpu_tick), .osc_tick(osc_tick), .lowclk_tick(lowclk_tick),
    .green_mode(green_mode), .btimer_irq(btimer_irq), .gtimer_irq(gtimer_irq),
    .btimer_wake(btimer_wake), .gtimer_wake(gtimer_wake), .shared_pin_out(shared_pin_out),
    .shared_pin_oe_n(shared_pin_oe_n), .second_timer_fast_sel(second_timer_fast_sel));

  always #2.5 clk_sys = ~clk_sys;

  // osc and low clock one pulse in four, so their rates differ from the cpu rate
  always @(posedge clk_sys) begin
    lc <= lc + 2'h1;
    osc_tick <= (lc == 2'h1);
    lowclk_tick <= (lc == 2'h3);
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // cycles up to the next wake pulse, -1 when none within lim + 1
  task automatic wait_wake(input logic gen, input int lim, input bit must);
    logic hit;
    cyc = 0;
    hit = 1'b0;
    while (!hit && cyc <= lim) begin
      @(posedge clk_sys);
      cyc++;
      hit = gen ? (gtimer_wake === 1'b1) : (btimer_wake === 1'b1);
    end
    if (!hit)
      cyc = -1;
    if (!hit && must) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask

  // interval between two steady overflows; the first may be partial
  task automatic measure(input logic gen, input int ex);
    wait_wake(gen, 2 * ex + 40, 1);
    wait_wake(gen, ex + 40, 1);
  endtask

  // stop, load reload and count, pick source, enable last
  task automatic gcfg(input logic fs, input logic wk, input logic [2:0] code,
                      input logic [2:0] low, input logic [7:0] rv);
    apb(1'b1, A_GM, 8'h00);
    apb(1'b1, A_GR, rv);
    apb(1'b1, A_GC, rv);
    apb(1'b1, A_BM, {5'h0, fs, wk, 1'b0});
    apb(1'b1, A_GM, {1'b1, code, 1'b0, low});
  endtask

  // stop and clear, set rate and source, load count, enable irq, enable last
  task automatic bcfg(input logic [7:0] mode, input logic [7:0] cnt);
    apb(1'b1, A_BM, 8'h00);
    apb(1'b1, A_IC, 8'h00);
    apb(1'b1, A_BM, mode & 8'h7F);
    apb(1'b1, A_BC, cnt);
    apb(1'b1, A_IC, 8'h02);
    apb(1'b1, A_BM, mode);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // reset values, refused addresses, reserved bit
    for (k = 0; k < 6; k++) begin
      apb(1'b0, al[k], 8'h00);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 12'h3FC, 8'h00);
    `CHK(err, 1'b1)
    apb(1'b1, A_BM + 12'h1, 8'hFF);
    `CHK(err, 1'b1)
    apb(1'b0, A_BM, 8'h00);
    `CHK(rd, 32'h0)
    apb(1'b1, A_GM, 8'h7F);
    apb(1'b0, A_GM, 8'h00);
    `CHK(rd, 32'h77)
    apb(1'b1, A_GM, 8'h00);
    apb(1'b1, A_BM, 8'h08);
    repeat (2) @(posedge clk_sys);
    `CHK(second_timer_fast_sel, 1'b1)
    $display("test registers done");
    // basic timer rates, request and read-back
    r = 8'($random(seed));
    apb(1'b1, A_IC, 8'h02);
    apb(1'b1, A_BC, r);
    apb(1'b0, A_BC, 8'h00);
    `CHK(rd, {24'h0, r})
    for (k = 7; k >= 6; k--) begin
      bcfg({1'b1, k[2:0], 4'h0}, r);
      measure(1'b0, 256 * (1 << (8 - k)));
      `CHK(cyc, 256 * (1 << (8 - k)))
    end
    repeat (2) @(posedge clk_sys);
    `CHK(btimer_irq, 1'b1)
    apb(1'b0, A_IC, 8'h00);
    `CHK(rd[1:0], 2'h3)
    // disabled basic timer holds and stays quiet
    apb(1'b1, A_BM, 8'h70);
    apb(1'b1, A_IC, 8'h02);
    apb(1'b0, A_BC, 8'h00);
    r = rd[7:0];
    repeat (1100) @(posedge clk_sys);
    apb(1'b0, A_BC, 8'h00);
    `CHK(rd, {24'h0, r})
    `CHK(btimer_irq, 1'b0)
    $display("test basic done");
    // real-time mode ignores rate and count
    r = 8'($random(seed));
    bcfg(8'h81, r);
    measure(1'b0, RTC_SIM * 4);
    `CHK(cyc, RTC_SIM * 4)
    `CHK(btimer_wake, 1'b1)
    apb(1'b0, A_BC, 8'h00);
    `CHK(rd, {24'h0, r})
    // awake system: time-outs still flag, but no wake pulse
    green_mode <= 1'b0;
    apb(1'b1, A_IC, 8'h02);
    wait_wake(1'b0, 80, 0);
    `CHK(cyc, -1)
    `CHK(btimer_irq, 1'b1)
    green_mode <= 1'b1;
    apb(1'b1, A_BM, 8'h00);
    $display("test rtc done");
    // every general rate code from both sources, with reload
    for (f = 0; f < 2; f++) begin
      for (k = 0; k < 8; k++) begin
        r = 8'hF8 | 8'($random(seed));
        e = (256 - r) * (f ? (4 << (7 - k)) : (1 << (8 - k)));
        gcfg(f[0], 1'b1, k[2:0], 3'b100, r);
        measure(1'b1, e);
        `CHK(cyc, e)
      end
    end
    apb(1'b0, A_IC, 8'h00);
    `CHK(rd[2], 1'b1)
    $display("test general rates done");
    // no reload: full 256-step period
    gcfg(1'b0, 1'b1, 3'h7, 3'b000, 8'hF8);
    measure(1'b1, 512);
    `CHK(cyc, 512)
    // toggle on the shared pin
    gcfg(1'b0, 1'b1, 3'h7, 3'b110, 8'hF8);
    repeat (2) @(posedge clk_sys);
    `CHK(shared_pin_oe_n, 1'b0)
    wait_wake(1'b1, 100, 1);
    p = shared_pin_out;
    wait_wake(1'b1, 100, 1);
    `CHK(shared_pin_out, ~p)
    gcfg(1'b0, 1'b1, 3'h7, 3'b100, 8'hF8);
    repeat (2) @(posedge clk_sys);
    `CHK(shared_pin_oe_n, 1'b1)
    // pwm forces reload even with the reload bit clear
    r = 8'hF8 | 8'($random(seed));
    gcfg(1'b0, 1'b1, 3'h7, 3'b001, r);
    measure(1'b1, (256 - r) * 2);
    `CHK(cyc, (256 - r) * 2)
    `CHK(shared_pin_oe_n, 1'b0)
    // halted general timer gives no time-out; an overflow in the halting
    // cycle itself still wakes one edge later, so let that edge pass
    apb(1'b1, A_GM, 8'h01);
    repeat (2) @(posedge clk_sys);
    wait_wake(1'b1, 200, 0);
    `CHK(cyc, -1)
    $display("test general output done");
    // wake bit clear: flag and request, but no wake
    gcfg(1'b0, 1'b0, 3'h7, 3'b100, 8'hF8);
    apb(1'b1, A_IC, 8'h08);
    wait_wake(1'b1, 100, 0);
    `CHK(cyc, -1)
    `CHK(gtimer_irq, 1'b1)
    $display("test wake done");
    print_verdict();
  end
endmodule
